// File: consec_fail.sv
`timescale 1ns/10ps
module consec_fail #(
    parameter int LIMIT = prot_pkg::FAIL_LIMIT
) (
    input  wire logic sys_clk_i,
    input  wire logic rst_b_i,
    input  wire logic eval_i,
    input  wire logic fail_i,
    output logic      trip_o
);
    localparam int CW = $clog2(LIMIT + 1);

    initial begin
        if (LIMIT < 1) begin
            $error("consec_fail: LIMIT must be at least 1");
        end
    end

    typedef struct packed {
        logic [CW-1:0] count;
        logic          trip;
    } cf_state_t;

    cf_state_t state;
    cf_state_t next_state;

    always_comb begin
        next_state = state;
        if (eval_i) begin
            if (!fail_i) begin
                next_state.count = '0;
            end else if (state.count != CW'(LIMIT)) begin
                next_state.count = state.count + CW'(1);
            end
            // Trip is sticky; only a reset clears it
            if (fail_i && (state.count == CW'(LIMIT - 1))) begin
                next_state.trip = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign trip_o = state.trip;
endmodule

// File: mains_and_temperature_protection.sv
`timescale 1ns/10ps
// Function
// - Line low 32 ms: stop, restart
// - Line above threshold clears brownout timer
// - Correction current half of excess over 6.24uA
// - No correction while control below 350 mV
// - Pin alternates line and temperature, 500us each
// - Source 200uA during temperature phase
// - Four failed temperature phases latch shutdown
// - Subtract held line current from source
// - Overvoltage sampled only in secondary stroke
// - Four cycles over 2.5 V latch shutdown
// - Ignore first 2us of secondary stroke
// - Latch stops switching until supply reset
// - Restart stops switching until UVLO with line back above threshold
module mains_and_temperature_protection #(
    parameter int PHASE_CYCLES    = prot_pkg::PHASE_CYC,
    parameter int BROWNOUT_CYCLES = prot_pkg::BROWNOUT_CYC
) (
    input  wire logic                         sys_clk_i,
    input  wire logic                         rst_b_i,
    input  wire prot_pkg::cmp_t               cmp_i,
    input  wire logic [prot_pkg::CUR_W-1:0]   line_code_i,
    input  wire logic                         line_code_valid_i,
    input  wire logic                         secondary_stroke_i,
    output prot_pkg::sense_ctrl_t             sense_ctrl_o,
    output logic                              stop_switching_o,
    output logic                              restart_req_o,
    output logic                              latch_req_o
);
    localparam int PW = $clog2(PHASE_CYCLES);
    localparam int BW = $clog2(BROWNOUT_CYCLES + 1);
    localparam int KW = $clog2(prot_pkg::BLANK_CYC + 1);
    localparam int CW = prot_pkg::CUR_W;

    initial begin
        if (PHASE_CYCLES < 2 || BROWNOUT_CYCLES < 1) begin
            $error("protection: cycle counts too small");
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        prot_pkg::cmp_t   sync1;
        prot_pkg::cmp_t   sync2;
        prot_pkg::phase_t phase;
        logic [PW-1:0]    phase_cnt;
        logic             line_below;   // Last line-phase comparator level
        logic [BW-1:0]    bo_cnt;
        logic [CW-1:0]    held_line;
        logic             low_all;
        logic             temp_eval;
        logic             temp_fail;
        logic             sec_prev;
        logic [KW-1:0]    blank_cnt;
        logic             ovp_seen;
        logic             ovp_eval;
        logic             ovp_fail;
        logic             restart;
        logic [CW-1:0]    opc;
        logic [CW-1:0]    temp_net;
    } state_t;

    state_t state;
    state_t next_state;
    logic   temp_trip;
    logic   ovp_trip;

    // Half of the excess over the knee, zero below it
    function automatic logic [CW-1:0] opc_of(input logic [CW-1:0] line);
        logic [CW-1:0] excess;
        excess = line - prot_pkg::OPC_KNEE_NA;
        if (line > prot_pkg::OPC_KNEE_NA) begin
            opc_of = excess >> 1;
        end else begin
            opc_of = prot_pkg::CUR_RESET;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_state = state;
        next_state.sync1 = cmp_i;
        next_state.sync2 = state.sync1;
        next_state.temp_eval = 1'b0;
        next_state.ovp_eval = 1'b0;

        // Phase sequencer
        if (state.phase_cnt == PW'(PHASE_CYCLES - 1)) begin
            next_state.phase_cnt = '0;
        end else begin
            next_state.phase_cnt = state.phase_cnt + PW'(1);
        end
        unique case (state.phase)
            prot_pkg::PH_LINE: begin
                next_state.line_below = state.sync2.line_below_bo;
                if (line_code_valid_i) begin
                    next_state.held_line = line_code_i;
                end
                if (state.phase_cnt == PW'(PHASE_CYCLES - 1)) begin
                    next_state.phase = prot_pkg::PH_TEMP;
                    next_state.low_all = 1'b1;
                end
            end
            prot_pkg::PH_TEMP: begin
                // One high sample anywhere passes the phase
                if (!state.sync2.protect_low) begin
                    next_state.low_all = 1'b0;
                end
                if (state.phase_cnt == PW'(PHASE_CYCLES - 1)) begin
                    next_state.phase = prot_pkg::PH_LINE;
                    next_state.temp_eval = 1'b1;
                    next_state.temp_fail =
                        state.low_all && state.sync2.protect_low;
                end
            end
            default: begin
                next_state.phase = prot_pkg::PH_LINE;
                next_state.phase_cnt = '0;
            end
        endcase

        // Brownout timer; holds the line level through the temp phase
        if (!state.line_below) begin
            next_state.bo_cnt = '0;
        end else if (state.bo_cnt != BW'(BROWNOUT_CYCLES)) begin
            next_state.bo_cnt = state.bo_cnt + BW'(1);
        end
        // Restart ends only when the supply has reached lockout
        if (state.sync2.supply_uvlo && !next_state.line_below) begin
            next_state.restart = 1'b0;
        end
        // Set after clear so a new brownout is never lost
        if (state.line_below && state.bo_cnt == BW'(BROWNOUT_CYCLES - 1)) begin
            next_state.restart = 1'b1;
        end

        // Line compensation, gated at low control level
        if (state.sync2.ctrl_low) begin
            next_state.opc = prot_pkg::CUR_RESET;
        end else begin
            next_state.opc = opc_of(state.held_line);
        end

        // Net thermistor current, floored at zero
        if (state.held_line > prot_pkg::TEMP_SOURCE_NA) begin
            next_state.temp_net = prot_pkg::CUR_RESET;
        end else begin
            next_state.temp_net =
                prot_pkg::TEMP_SOURCE_NA - state.held_line;
        end

        // Output overvoltage during the secondary stroke only
        next_state.sec_prev = secondary_stroke_i;
        if (secondary_stroke_i) begin
            if (!state.sec_prev) begin
                next_state.blank_cnt = '0;
                next_state.ovp_seen = 1'b0;
            end else if (state.blank_cnt != KW'(prot_pkg::BLANK_CYC)) begin
                next_state.blank_cnt = state.blank_cnt + KW'(1);
            end
            // Ringing at stroke start is not looked at
            if (state.sec_prev &&
                state.blank_cnt == KW'(prot_pkg::BLANK_CYC) &&
                state.sync2.sense_over) begin
                next_state.ovp_seen = 1'b1;
            end
        end else if (state.sec_prev) begin
            // End of stroke closes one switching cycle
            next_state.ovp_eval = 1'b1;
            next_state.ovp_fail = state.ovp_seen;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= '{
                sync1:     prot_pkg::CMP_RESET,
                sync2:     prot_pkg::CMP_RESET,
                phase:     prot_pkg::PH_LINE,
                phase_cnt: '0,
                line_below: 1'b0,
                bo_cnt:    '0,
                held_line: prot_pkg::CUR_RESET,
                low_all:   1'b0,
                temp_eval: 1'b0,
                temp_fail: 1'b0,
                sec_prev:  1'b0,
                blank_cnt: '0,
                ovp_seen:  1'b0,
                ovp_eval:  1'b0,
                ovp_fail:  1'b0,
                restart:   1'b0,
                opc:       prot_pkg::CUR_RESET,
                temp_net:  prot_pkg::TEMP_SOURCE_NA
            };
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Consecutive-failure counters

    consec_fail #(
        .LIMIT (prot_pkg::FAIL_LIMIT)
    ) temp_check (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .eval_i    (state.temp_eval),
        .fail_i    (state.temp_fail),
        .trip_o    (temp_trip)
    );

    consec_fail #(
        .LIMIT (prot_pkg::FAIL_LIMIT)
    ) ovp_check (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .eval_i    (state.ovp_eval),
        .fail_i    (state.ovp_fail),
        .trip_o    (ovp_trip)
    );

    ////////////////////////////////////////////////////////////////////
    // Outputs

    // Latch holds until the supply drops below reset level (rst_b_i)
    assign latch_req_o      = temp_trip | ovp_trip;
    assign restart_req_o    = state.restart & ~latch_req_o;
    assign stop_switching_o = latch_req_o | state.restart;

    assign sense_ctrl_o.temp_phase     = (state.phase == prot_pkg::PH_TEMP);
    assign sense_ctrl_o.line_clamp_en  = (state.phase == prot_pkg::PH_LINE);
    assign sense_ctrl_o.temp_source_en =
        (state.phase == prot_pkg::PH_TEMP);
    assign sense_ctrl_o.opc_current    = state.opc;
    assign sense_ctrl_o.temp_net       = state.temp_net;
endmodule

// File: power_stage_model.sv
`timescale 1ns/10ps
module power_stage_model #(
    parameter int BO_NA = 5000
) (
    input  wire prot_pkg::sense_ctrl_t ctrl_i,
    input  wire logic [17:0]           line_na_i,
    input  wire logic                  hot_i,
    input  wire logic                  ovp_i,
    input  wire logic                  uvlo_i,
    input  wire logic                  ctrl_low_i,
    output prot_pkg::cmp_t             cmp_o,
    output logic [17:0]                line_code_o,
    output logic                       line_code_valid_o
);
    assign cmp_o.line_below_bo = (line_na_i < 18'(BO_NA));
    // Clamped pin sits at 0.25 V; unsourced NTC pulls it low as well
    assign cmp_o.protect_low = ctrl_i.line_clamp_en
        | (ctrl_i.temp_source_en ? hot_i : 1'b1);
    assign cmp_o.sense_over  = ovp_i;
    assign cmp_o.supply_uvlo = uvlo_i;
    assign cmp_o.ctrl_low    = ctrl_low_i;
    // Code is junk outside the line phase
    assign line_code_o = ctrl_i.line_clamp_en ? line_na_i : ~line_na_i;
    assign line_code_valid_o = ctrl_i.line_clamp_en;
endmodule

// File: prot_chk_sva.sv
`timescale 1ns/10ps
module prot_chk #(
    parameter int PHASE_CYCLES    = 20,
    parameter int BROWNOUT_CYCLES = 100
) (
    input  wire logic                  sys_clk_i,
    input  wire logic                  rst_b_i,
    input  wire prot_pkg::cmp_t        cmp_i,
    input  wire prot_pkg::sense_ctrl_t sense_ctrl_o,
    input  wire logic                  stop_switching_o,
    input  wire logic                  restart_req_o,
    input  wire logic                  latch_req_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    logic prev_ph;
    int   ph_cnt;
    int   low_cnt;
    ////////////////////////////////////////////////////////////////////////
    // Phase age and raw line-low age
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prev_ph <= 1'b0;
            ph_cnt  <= 0;
            low_cnt <= 0;
        end else begin
            prev_ph <= sense_ctrl_o.temp_phase;
            ph_cnt  <= (sense_ctrl_o.temp_phase != prev_ph) ? 1 : ph_cnt + 1;
            if (!cmp_i.line_below_bo)
                low_cnt <= 0;
            else if (low_cnt < 100000)
                low_cnt <= low_cnt + 1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    chk_latch_hold: assert property (latch_req_o |=> latch_req_o)
        else $error("latch request dropped");
    chk_latch_stop: assert property (latch_req_o |-> stop_switching_o)
        else $error("latch without stop");
    chk_restart_stop:
        assert property (restart_req_o |-> stop_switching_o)
        else $error("restart without stop");
    chk_source_phase:
        assert property (sense_ctrl_o.temp_source_en == sense_ctrl_o.temp_phase
            && sense_ctrl_o.line_clamp_en != sense_ctrl_o.temp_phase)
        else $error("source or clamp out of phase");
    chk_phase_len:
        assert property (sense_ctrl_o.temp_phase != prev_ph
            |-> ph_cnt == PHASE_CYCLES)
        else $error("phase length wrong");
    chk_opc_off:
        assert property (cmp_i.ctrl_low [*4] |-> sense_ctrl_o.opc_current == '0)
        else $error("correction active at low control");
    chk_bo_early:
        assert property ($rose(restart_req_o)
            |-> low_cnt >= BROWNOUT_CYCLES - PHASE_CYCLES)
        else $error("brownout restart too early");
    chk_bo_late:
        assert property (low_cnt == BROWNOUT_CYCLES + PHASE_CYCLES + 8
            |-> restart_req_o || latch_req_o)
        else $error("brownout restart missing");
    cover property ($rose(latch_req_o));
    cover property ($rose(restart_req_o));
    cover property ($rose(sense_ctrl_o.temp_phase));
endmodule

bind mains_and_temperature_protection prot_chk #(
    .PHASE_CYCLES   (PHASE_CYCLES),
    .BROWNOUT_CYCLES(BROWNOUT_CYCLES)
) u_chk (
    .sys_clk_i       (sys_clk_i),
    .rst_b_i         (rst_b_i),
    .cmp_i           (cmp_i),
    .sense_ctrl_o    (sense_ctrl_o),
    .stop_switching_o(stop_switching_o),
    .restart_req_o   (restart_req_o),
    .latch_req_o     (latch_req_o)
);

// File: prot_pkg.sv
package prot_pkg;

    // Clock
    localparam int CLK_HZ          = 25_000_000;

    // Times, in the unit printed
    localparam int PHASE_US        = 500;
    localparam int BROWNOUT_MS     = 32;
    localparam int BLANK_US        = 2;

    // Cycle counts derived from the times
    localparam int PHASE_CYC       = (PHASE_US * (CLK_HZ / 1000)) / 1000;
    localparam int BROWNOUT_CYC    = BROWNOUT_MS * (CLK_HZ / 1000);
    localparam int BLANK_CYC       =
        (BLANK_US * (CLK_HZ / 1000) + 999) / 1000;

    // Consecutive failures that trip a latch
    localparam int FAIL_LIMIT      = 4;

    // Current codes, one LSB is 1 nA
    localparam int CUR_W           = 18;
    localparam logic [CUR_W-1:0] OPC_KNEE_NA    = 18'h01860; // 6.24 uA
    localparam logic [CUR_W-1:0] TEMP_SOURCE_NA = 18'h30d40; // 200 uA
    localparam logic [CUR_W-1:0] CUR_RESET      = 18'h00000;

    // Measurement phase, one-hot
    typedef enum logic [1:0] {
        PH_LINE = 2'b01,
        PH_TEMP = 2'b10
    } phase_t;

    // Analog comparator levels, asynchronous to sys_clk_i
    typedef struct packed {
        logic line_below_bo;   // Line-detect current below brownout level
        logic ctrl_low;        // Peak-current control level below 350 mV
        logic protect_low;     // Protection sense pin below 2.0 V
        logic sense_over;      // current_sense_pin above 2.5 V
        logic supply_uvlo;     // Supply below undervoltage lockout
    } cmp_t;

    // Controls toward the analog sense network
    typedef struct packed {
        logic             temp_phase;    // 1: temperature phase
        logic             line_clamp_en; // Clamp pin for line detect
        logic             temp_source_en;// 200 uA source on
        logic [CUR_W-1:0] opc_current;   // Correction current, nA
        logic [CUR_W-1:0] temp_net;      // Source minus held line, nA
    } sense_ctrl_t;

    localparam cmp_t CMP_RESET = '{default: 1'b0};

endpackage

// File: tb.sv
`timescale 1ns/10ps
module tb;
    localparam int P = 20;
    localparam int B = 100;
    logic                  clk = 1'b0;
    logic                  rst_b = 1'b0;
    logic [17:0]           line_na = 18'h02710;
    logic                  hot = 1'b0, ovp = 1'b0, uvlo = 1'b0;
    logic                  ctrl_low = 1'b0, stroke = 1'b0;
    prot_pkg::cmp_t        cmp;
    prot_pkg::sense_ctrl_t ctrl;
    logic [17:0]           code;
    logic                  vld, stop, rs, lt;
    int                    failures = 0, checked = 0;
    always #20 clk = ~clk;
    power_stage_model u_ps (.ctrl_i(ctrl), .line_na_i(line_na), .hot_i(hot),
        .ovp_i(ovp), .uvlo_i(uvlo), .ctrl_low_i(ctrl_low), .cmp_o(cmp),
        .line_code_o(code), .line_code_valid_o(vld));
    mains_and_temperature_protection #(.PHASE_CYCLES(P), .BROWNOUT_CYCLES(B))
        u_dut (.sys_clk_i(clk), .rst_b_i(rst_b), .cmp_i(cmp),
        .line_code_i(code), .line_code_valid_i(vld),
        .secondary_stroke_i(stroke), .sense_ctrl_o(ctrl),
        .stop_switching_o(stop), .restart_req_o(rs), .latch_req_o(lt));
    ////////////////////////////////////////////////////////////////////////
    task end_sim;
        if (failures == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [17:0] seen, input logic [17:0] exp, input string m);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Bounded wait for latch (sel 0) or restart (sel 1) to reach lvl
    task wait_out(input bit sel, input logic lvl, input int lim);
        for (int i = 0; i < lim; i++) begin
            cyc(1);
            #1;
            if ((sel ? rs : lt) === lvl)
                return;
        end
        failures++;
        $display("wrong value at %0t: request wait timed out", $time);
        end_sim();
    endtask
    task do_reset;
        cyc(1);
        rst_b <= 1'b0;
        cyc(10);
        rst_b <= 1'b1;
    endtask
    task stroke_once(input int len, input int from, input int to, input bit pr);
        cyc(1);
        ovp <= pr;
        cyc(30);
        for (int i = 0; i < len; i++) begin
            stroke <= 1'b1;
            ovp    <= (i >= from && i < to);
            cyc(1);
        end
        stroke <= 1'b0;
        ovp    <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_reset;
        #1;
        chk(ctrl.temp_phase, 0, "phase after reset");
        chk(ctrl.temp_net, 18'h30d40, "net after reset");
        chk(stop, 0, "stop after reset");
        cyc(P + 5);
        #1;
        chk(ctrl.temp_source_en, 1, "source in temp phase");
    endtask
    task t_opc;
        int ln[5] = '{6240, 6241, 7240, 18240, 18240};
        int lo[5] = '{0, 0, 0, 0, 1};
        int op[5] = '{0, 0, 500, 6000, 0};
        for (int k = 0; k < 5; k++) begin
            cyc(1);
            line_na  <= 18'(ln[k]);
            ctrl_low <= lo[k][0];
            cyc(2 * P + 6);
            #1;
            chk(ctrl.opc_current, 18'(op[k]), "correction");
            chk(ctrl.temp_net, 18'(200000 - ln[k]), "net");
        end
        cyc(1);
        line_na  <= 18'h02710;
        ctrl_low <= 1'b0;
    endtask
    task t_brownout;
        repeat (4) begin
            cyc(1);
            line_na <= 18'h00fa0;
            cyc(60);
            line_na <= 18'h02710;
            cyc(30);
        end
        #1;
        chk(rs, 0, "ripple restart");
        cyc(1);
        line_na <= 18'h00fa0;
        wait_out(1, 1'b1, B + P + 20);
        chk(stop, 1, "brownout stop");
        cyc(1);
        line_na <= 18'h02710;
        uvlo    <= 1'b1;
        wait_out(1, 1'b0, 3 * P);
        cyc(1);
        uvlo <= 1'b0;
    endtask
    task t_temp;
        repeat (40) begin
            cyc(10);
            hot <= ~hot;
        end
        cyc(1);
        hot <= 1'b1;
        cyc(120);
        hot <= 1'b0;
        cyc(80);
        hot <= 1'b1;
        cyc(120);
        #1;
        chk(lt, 0, "temperature latch early");
        wait_out(0, 1'b1, 120);
        chk(stop, 1, "latch stop");
        cyc(1);
        hot <= 1'b0;
    endtask
    task t_ovp;
        bit [7:0] pat = 8'b1111_0111;
        repeat (4) stroke_once(100, 0, 40, 1'b0);
        repeat (4) stroke_once(100, 0, 0, 1'b1);
        #1;
        chk(lt, 0, "blanked or primary sample");
        for (int k = 0; k < 7; k++)
            stroke_once(100, pat[k] ? 70 : 0, pat[k] ? 90 : 0, 1'b0);
        #1;
        chk(lt, 0, "overvoltage latch early");
        stroke_once(100, 70, 90, 1'b0);
        wait_out(0, 1'b1, 10);
    endtask
    initial begin
        do_reset();
        t_reset();
        t_opc();
        t_brownout();
        t_temp();
        do_reset();
        t_ovp();
        end_sim();
    end
endmodule
